// ---- src/asss_axis.sv ----
// one axis: post-stop vibration restriction and synchronous start, AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`default_nettype none

module asss_axis
  import asss_pkg::*;
#(
  parameter int AXIS_ID = 0
) (
  input wire logic aclk,
  input wire logic aresetn,
  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // ************************************************************
  // axis pulse engine side
  // ************************************************************
  input wire logic start_cmd,
  input wire logic cmd_done,
  input wire logic feed_dir_pos,
  input wire asss_evt_t events,
  input wire logic [ASSS_NUM_AXES-1:0] axis_running,
  input wire logic [ASSS_NUM_AXES-1:0] axis_sync_in,
  output logic go_q,
  output asss_extra_t extra_q,
  output logic sync_out_q,
  output logic int_n_q
);

  // refused at elaboration, not at run time
  if (AXIS_ID < 0 || AXIS_ID >= ASSS_NUM_AXES) begin : g_bad_id
    $error("asss_axis: AXIS_ID out of range");
  end

  localparam int EW = ASSS_EVT_MSB - ASSS_EVT_LSB + 1;

  // ************************************************************
  // register storage
  // ************************************************************
  logic [31:0] vib_timing_q;
  logic [31:0] op_mode_q;
  logic [31:0] env_two_q;
  logic [31:0] sync_cfg_q;
  logic [31:0] irq_en_q;
  logic [EW-1:0] cause_q;
  logic [EW-1:0] cause_d;
  logic [3:0] op_status;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // address and data are taken together, so a lone channel waits
  wire aw_take = s_axi_awready && s_axi_awvalid;
  wire [7:0] waddr = {s_axi_awaddr[7:2], 2'b00};
  wire wr_vib = aw_take && (waddr == ASSS_OFS_VIB_TIMING);
  wire wr_mode = aw_take && (waddr == ASSS_OFS_OP_MODE);
  wire wr_env = aw_take && (waddr == ASSS_OFS_ENV_TWO);
  wire wr_sync = aw_take && (waddr == ASSS_OFS_SYNC_CFG);
  wire wr_irq = aw_take && (waddr == ASSS_OFS_IRQ_EN);
  wire wr_cause = aw_take && (waddr == ASSS_OFS_CAUSE);
  wire wr_status = aw_take && (waddr == ASSS_OFS_EXT_STATUS);
  wire wr_hit = wr_vib | wr_mode | wr_env | wr_sync | wr_irq | wr_cause | wr_status;
  wire [31:0] wmask = merge_bytes(32'h0000_0000, 32'hffff_ffff, s_axi_wstrb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ASSS_RESP_OKAY;
    end else begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      if (aw_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ASSS_RESP_OKAY : ASSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vib_timing_q <= ASSS_RST_REG;
      op_mode_q <= ASSS_RST_REG;
      env_two_q <= ASSS_RST_REG;
      sync_cfg_q <= ASSS_RST_REG;
      irq_en_q <= ASSS_RST_REG;
    end else begin
      if (wr_vib) begin
        vib_timing_q <= merge_bytes(vib_timing_q, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_mode) begin
        op_mode_q <= merge_bytes(op_mode_q, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_env) begin
        env_two_q <= merge_bytes(env_two_q, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_sync) begin
        sync_cfg_q <= merge_bytes(sync_cfg_q, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_irq) begin
        irq_en_q <= merge_bytes(irq_en_q, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  wire ar_take = s_axi_arready && s_axi_arvalid;
  wire [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  wire rd_status = (raddr == ASSS_OFS_EXT_STATUS);
  wire rd_cause = (raddr == ASSS_OFS_CAUSE);
  wire rd_wo = (raddr == ASSS_OFS_VIB_TIMING) || (raddr == ASSS_OFS_OP_MODE) ||
               (raddr == ASSS_OFS_ENV_TWO) || (raddr == ASSS_OFS_SYNC_CFG) ||
               (raddr == ASSS_OFS_IRQ_EN);
  wire [31:0] cause_word = 32'(cause_q) << ASSS_EVT_LSB;
  // setting registers are write only and read back as zero
  wire [31:0] rd_word = rd_status ? {28'h000_0000, op_status} :
                        rd_cause ? cause_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ASSS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_status || rd_cause || rd_wo) ? ASSS_RESP_OKAY : ASSS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // vibration restriction
  // ************************************************************
  typedef enum logic [1:0] {VIB_IDLE, VIB_REV_WAIT, VIB_FWD_WAIT} asss_vib_state_t;
  asss_vib_state_t vib_q;
  asss_vib_state_t vib_d;

  wire [ASSS_DELAY_W-1:0] rev_delay = vib_timing_q[ASSS_REV_LSB +: ASSS_DELAY_W];
  wire [ASSS_DELAY_W-1:0] fwd_delay = vib_timing_q[ASSS_FWD_LSB +: ASSS_DELAY_W];
  wire vib_enabled = (rev_delay != '0) && (fwd_delay != '0);
  wire vib_begin = (vib_q == VIB_IDLE) && cmd_done && vib_enabled;
  logic tmr_done;
  wire rev_fire = (vib_q == VIB_REV_WAIT) && tmr_done;
  wire fwd_fire = (vib_q == VIB_FWD_WAIT) && tmr_done;
  // reverse pulse restarts the timer with the forward delay
  wire tmr_start = vib_begin || rev_fire;
  wire [ASSS_DELAY_W-1:0] tmr_units = vib_begin ? rev_delay : fwd_delay;
  logic feed_pos_q;

  asss_unit_timer #(
    .W(ASSS_DELAY_W),
    .UNIT(ASSS_UNIT_CLKS)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tmr_start),
    .units(tmr_units),
    .done_q(tmr_done)
  );

  always_comb begin
    vib_d = vib_q;
    unique case (vib_q)
      VIB_IDLE: begin
        if (vib_begin) begin
          vib_d = VIB_REV_WAIT;
        end
      end
      VIB_REV_WAIT: begin
        if (rev_fire) begin
          vib_d = VIB_FWD_WAIT;
        end
      end
      VIB_FWD_WAIT: begin
        if (fwd_fire) begin
          vib_d = VIB_IDLE;
        end
      end
    endcase
  end

  // direction of the finished command is latched so the pair mirrors it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vib_q <= VIB_IDLE;
      feed_pos_q <= 1'b1;
      extra_q <= '0;
    end else begin
      vib_q <= vib_d;
      if (vib_begin) begin
        feed_pos_q <= feed_dir_pos;
      end
      extra_q.pulse <= rev_fire || fwd_fire;
      if (rev_fire) begin
        extra_q.dir_pos <= !feed_pos_q;
      end else if (fwd_fire) begin
        extra_q.dir_pos <= feed_pos_q;
      end
      extra_q.active <= (vib_d != VIB_IDLE);
    end
  end

  // ************************************************************
  // synchronous start
  // ************************************************************
  typedef enum logic [1:0] {SY_IDLE, SY_WAIT_SYNC, SY_WAIT_STOP} asss_sync_state_t;
  asss_sync_state_t sy_q;
  asss_sync_state_t sy_d;

  wire [1:0] start_cond = op_mode_q[ASSS_START_COND_LSB +: 2];
  wire [ASSS_NUM_AXES-1:0] stop_mask_raw = op_mode_q[ASSS_STOP_MASK_LSB +: ASSS_NUM_AXES];
  wire auto_assign = env_two_q[ASSS_AUTO_ASSIGN_BIT];
  wire [ASSS_NUM_AXES-1:0] own_bit = ASSS_NUM_AXES'(1) << AXIS_ID;
  // legacy mode never watches its own axis
  wire [ASSS_NUM_AXES-1:0] stop_mask =
      auto_assign ? stop_mask_raw : (stop_mask_raw & ~own_bit);
  wire [1:0] sync_in_sel = sync_cfg_q[ASSS_SYNC_IN_LSB +: 2];
  wire sync_in_hit = axis_sync_in[sync_in_sel];

  logic [ASSS_NUM_AXES-1:0] run_prev_q;
  logic [ASSS_NUM_AXES-1:0] seen_stop_q;
  wire [ASSS_NUM_AXES-1:0] fell = run_prev_q & ~axis_running;
  wire [ASSS_NUM_AXES-1:0] seen_now = seen_stop_q | fell;
  wire all_stopped = ((stop_mask & ~axis_running) == stop_mask);
  // legacy needs a fresh running-to-stopped change, else stale stops would count
  wire legacy_ok = all_stopped && |(stop_mask & seen_now);
  wire auto_ok = all_stopped && (stop_mask != '0);
  wire stop_ok = auto_assign ? auto_ok : legacy_ok;
  wire go_now = ((sy_q == SY_WAIT_SYNC) && sync_in_hit) ||
                ((sy_q == SY_WAIT_STOP) && stop_ok) ||
                ((sy_q == SY_IDLE) && start_cmd &&
                 (start_cond != ASSS_COND_SYNC) && (start_cond != ASSS_COND_STOP));

  always_comb begin
    sy_d = sy_q;
    unique case (sy_q)
      SY_IDLE: begin
        if (start_cmd && (start_cond == ASSS_COND_SYNC)) begin
          sy_d = SY_WAIT_SYNC;
        end else if (start_cmd && (start_cond == ASSS_COND_STOP)) begin
          sy_d = SY_WAIT_STOP;
        end
      end
      SY_WAIT_SYNC: begin
        if (sync_in_hit) begin
          sy_d = SY_IDLE;
        end
      end
      SY_WAIT_STOP: begin
        if (stop_ok) begin
          sy_d = SY_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy_q <= SY_IDLE;
      run_prev_q <= '0;
      seen_stop_q <= '0;
      go_q <= 1'b0;
    end else begin
      sy_q <= sy_d;
      run_prev_q <= axis_running;
      seen_stop_q <= (sy_q == SY_WAIT_STOP) ? seen_now : '0;
      go_q <= go_now;
    end
  end

  // waiting codes leave as soon as the condition has been met
  assign op_status = (sy_q == SY_WAIT_SYNC) ? ASSS_ST_WAIT_SYNC :
                     (sy_q == SY_WAIT_STOP) ? ASSS_ST_WAIT_STOP :
                     axis_running[AXIS_ID] ? ASSS_ST_RUN : ASSS_ST_IDLE;

  // ************************************************************
  // internal sync output and event interrupt
  // ************************************************************
  wire [3:0] sync_src = sync_cfg_q[ASSS_SYNC_OUT_LSB +: 4];
  wire [3:0] profile = {events.decel_end, events.decel_start, events.accel_end,
                        events.accel_start};
  wire src_is_cmp = (sync_src >= ASSS_SRC_CMP_FIRST) && (sync_src <= ASSS_SRC_CMP_LAST);
  wire src_is_prof = (sync_src[3:2] == ASSS_SRC_PROFILE_HI);
  wire [2:0] cmp_idx = 3'(sync_src - ASSS_SRC_CMP_FIRST);
  wire sync_hit = src_is_cmp ? events.cmp_hit[cmp_idx] :
                  src_is_prof ? profile[sync_src[1:0]] :
                  1'b0;

  // cause bits 4..12 line up with the enable bits
  wire [EW-1:0] evt_vec = {events.cmp_hit, profile};
  wire [EW-1:0] irq_en = irq_en_q[ASSS_EVT_MSB:ASSS_EVT_LSB];
  wire [EW-1:0] cause_set = evt_vec & irq_en;
  wire [EW-1:0] cause_clr = wr_cause ? (s_axi_wdata[ASSS_EVT_MSB:ASSS_EVT_LSB] &
                                        wmask[ASSS_EVT_MSB:ASSS_EVT_LSB]) : '0;
  // new event beats a simultaneous write-one-to-clear
  assign cause_d = (cause_q & ~cause_clr) | cause_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= '0;
      sync_out_q <= 1'b0;
      int_n_q <= 1'b1;
    end else begin
      cause_q <= cause_d;
      sync_out_q <= sync_hit;
      int_n_q <= !(|(cause_d & irq_en));
    end
  end

endmodule : asss_axis

`default_nettype wire

// ---- src/asss_pkg.sv ----
// constants and carrier types for the axis settle and sync start block
`default_nettype none

package asss_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ASSS_OFS_VIB_TIMING = 8'h00;
  localparam logic [7:0] ASSS_OFS_OP_MODE = 8'h04;
  localparam logic [7:0] ASSS_OFS_ENV_TWO = 8'h08;
  localparam logic [7:0] ASSS_OFS_SYNC_CFG = 8'h0c;
  localparam logic [7:0] ASSS_OFS_EXT_STATUS = 8'h10;
  localparam logic [7:0] ASSS_OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] ASSS_OFS_CAUSE = 8'h18;

  localparam logic [31:0] ASSS_RST_REG = 32'h0000_0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ASSS_REV_LSB = 0;
  localparam int ASSS_FWD_LSB = 16;
  localparam int ASSS_DELAY_W = 16;
  localparam int ASSS_START_COND_LSB = 18;
  localparam int ASSS_STOP_MASK_LSB = 20;
  localparam int ASSS_AUTO_ASSIGN_BIT = 29;
  localparam int ASSS_SYNC_OUT_LSB = 16;
  localparam int ASSS_SYNC_IN_LSB = 20;
  localparam int ASSS_EVT_LSB = 4;
  localparam int ASSS_EVT_MSB = 12;
  localparam int ASSS_NUM_AXES = 4;

  // ************************************************************
  // codes
  // ************************************************************
  localparam logic [1:0] ASSS_COND_SYNC = 2'h2;
  localparam logic [1:0] ASSS_COND_STOP = 2'h3;
  localparam logic [3:0] ASSS_SRC_CMP_FIRST = 4'h1;
  localparam logic [3:0] ASSS_SRC_CMP_LAST = 4'h5;
  localparam logic [1:0] ASSS_SRC_PROFILE_HI = 2'h2;
  localparam logic [3:0] ASSS_ST_IDLE = 4'h0;
  localparam logic [3:0] ASSS_ST_RUN = 4'h1;
  localparam logic [3:0] ASSS_ST_WAIT_SYNC = 4'h3;
  localparam logic [3:0] ASSS_ST_WAIT_STOP = 4'h4;
  localparam logic [1:0] ASSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASSS_RESP_SLVERR = 2'h2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int ASSS_UNIT_CLKS = 32;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [4:0] cmp_hit;
    logic decel_end;
    logic decel_start;
    logic accel_end;
    logic accel_start;
  } asss_evt_t;

  typedef struct packed {
    logic pulse;
    logic dir_pos;
    logic active;
  } asss_extra_t;

endpackage : asss_pkg

`default_nettype wire

// ---- src/asss_unit_timer.sv ----
// delay timer counting in units of a fixed number of clock cycles
`default_nettype none

module asss_unit_timer
  import asss_pkg::*;
#(
  parameter int W = ASSS_DELAY_W,
  parameter int UNIT = ASSS_UNIT_CLKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [W-1:0] units,
  output logic done_q
);

  localparam int PW = (UNIT > 1) ? $clog2(UNIT) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(UNIT - 1);

  // refused at elaboration, not at run time
  if (W < 1 || UNIT < 2) begin : g_bad_cfg
    $error("asss_unit_timer: unsupported width or unit");
  end

  logic busy_q;
  logic [PW-1:0] pre_q;
  logic [W-1:0] cnt_q;
  wire unit_tick = busy_q && (pre_q == PRE_LAST);
  wire last_unit = (cnt_q == W'(1));

  // units of zero are started by the owner only if the forward delay is cleared during the reverse wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      pre_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= unit_tick && last_unit;
      if (start) begin
        busy_q <= 1'b1;
        pre_q <= '0;
        cnt_q <= units;
      end else if (busy_q) begin
        pre_q <= unit_tick ? '0 : pre_q + PW'(1);
        if (unit_tick) begin
          cnt_q <= cnt_q - W'(1);
          busy_q <= !last_unit;
        end
      end
    end
  end

endmodule : asss_unit_timer

`default_nettype wire

// ---- testbench/asss_axis_props.sv ----
// concurrent checks on the ports of the axis settle and sync start block
`default_nettype none
module asss_axis_props
  import asss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_done,
  input wire asss_evt_t events,
  input wire logic go_q,
  input wire asss_extra_t extra_q,
  input wire logic sync_out_q,
  input wire logic int_n_q
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_write_ready: assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid)
    else $error("write ready without request");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  chk_settle_cause: assert property ($rose(extra_q.active) |-> $past(cmd_done))
    else $error("settle sequence without command end");
  // a delay of one unit already keeps the line quiet for 33 cycles
  chk_reverse_gap: assert property ($rose(extra_q.active) |-> !extra_q.pulse [*8])
    else $error("reverse pulse too early");
  chk_pulse_single: assert property (extra_q.pulse |=> !extra_q.pulse)
    else $error("extra pulse wider than one cycle");
  chk_sync_cause: assert property (sync_out_q |-> |$past(events))
    else $error("sync output without event");
  chk_irq_cause: assert property ($fell(int_n_q) |-> |$past(events))
    else $error("interrupt without event");
  cov_go: cover property (go_q);
  cov_extra: cover property (extra_q.pulse);
  cov_irq: cover property ($fell(int_n_q) && sync_out_q);
endmodule : asss_axis_props
bind asss_axis asss_axis_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .cmd_done,
  .events, .go_q, .extra_q, .sync_out_q, .int_n_q);
`default_nettype wire

// ---- testbench/asss_axis_tb.sv ----
// self-checking bench for the axis settle and sync start block
`default_nettype none
module asss_axis_tb import asss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, axis_running = 4'h0, axis_sync_in = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic start_cmd = 1'b0, cmd_done = 1'b0, feed_dir_pos = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic go_q, sync_out_q, int_n_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] rev_cnt_q, fwd_cnt_q;
  asss_evt_t events = 9'h000;
  asss_extra_t extra_q;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  asss_axis u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .start_cmd, .cmd_done, .feed_dir_pos, .events,
    .axis_running, .axis_sync_in, .go_q, .extra_q, .sync_out_q, .int_n_q);
  asss_drv_model u_drv (.aclk, .aresetn, .extra_q, .rev_cnt_q, .fwd_cnt_q);
  always #2.5 aclk = ~aclk;
  // ****************************************
  // shared tasks
  // ****************************************
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic sts(input logic [3:0] e);
    rd(ASSS_OFS_EXT_STATUS);
    chk("status", {28'h0, e}, d);
  endtask : sts
  function automatic logic pick(input int w);
    return w == 0 ? go_q : (w == 1 ? extra_q.pulse : sync_out_q);
  endfunction : pick
  // strobes raised before the call are dropped at its first edge
  task automatic wait_sig(input int w, input int lim);
    @(posedge aclk);
    start_cmd <= 1'b0;
    cmd_done <= 1'b0;
    axis_sync_in <= 4'h0;
    events <= 9'h000;
    #1;
    n = 1;
    while (pick(w) !== 1'b1 && n < lim) begin
      @(posedge aclk);
      #1;
      n++;
    end
  endtask : wait_sig
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_stuck;
    wr(ASSS_OFS_OP_MODE, 32'h004c_0000);
    @(posedge aclk);
    start_cmd <= 1'b1;
    wait_sig(0, 30);
    chk("stopped axis start", 30, n);
    sts(ASSS_ST_WAIT_STOP);
  endtask : t_stuck
  task automatic t_vib;
    rd(ASSS_OFS_VIB_TIMING);
    chk("wo read", 32'h0, d);
    wr(ASSS_OFS_VIB_TIMING, 32'h0001_0002);
    chk("write okay", 32'h0, {30'h0, r});
    @(posedge aclk);
    cmd_done <= 1'b1;
    wait_sig(1, 400);
    chk("reverse delay", 66, n);
    chk("reverse dir", 0, extra_q.dir_pos);
    wait_sig(1, 400);
    // forward timer starts on the reverse pulse edge, its registered output adds one
    chk("forward delay", 33, n);
    chk("forward dir", 1, extra_q.dir_pos);
    wr(ASSS_OFS_VIB_TIMING, 32'h0000_0003);
    @(posedge aclk);
    cmd_done <= 1'b1;
    wait_sig(1, 300);
    chk("pulse count", 32'h0101, {rev_cnt_q, fwd_cnt_q});
  endtask : t_vib
  task automatic t_sync;
    @(posedge aclk);
    start_cmd <= 1'b1;
    wait_sig(0, 4);
    chk("plain start", 1, n);
    wr(ASSS_OFS_OP_MODE, 32'h0008_0000);
    for (int i = 0; i < 4; i++) begin
      wr(ASSS_OFS_SYNC_CFG, 32'(i) << 20);
      @(posedge aclk);
      start_cmd <= 1'b1;
      wait_sig(0, 4);
      sts(ASSS_ST_WAIT_SYNC);
      @(posedge aclk);
      axis_sync_in <= 4'(1 << ((i + 1) % 4));
      wait_sig(0, 4);
      chk("wrong axis", 4, n);
      @(posedge aclk);
      axis_sync_in <= 4'(1 << i);
      wait_sig(0, 4);
      chk("sync start", 1, n);
      sts(ASSS_ST_IDLE);
    end
  endtask : t_sync
  // own axis stays running, so only its exclusion lets the start happen
  task automatic t_stop;
    wr(ASSS_OFS_OP_MODE, 32'h003c_0000);
    @(posedge aclk);
    axis_running <= 4'h3;
    start_cmd <= 1'b1;
    wait_sig(0, 6);
    chk("running axis start", 6, n);
    sts(ASSS_ST_WAIT_STOP);
    @(posedge aclk);
    axis_running <= 4'h1;
    wait_sig(0, 6);
    chk("stop start", 1, n);
    sts(ASSS_ST_RUN);
    wr(ASSS_OFS_ENV_TWO, 32'h2000_0000);
    wr(ASSS_OFS_OP_MODE, 32'h001c_0000);
    @(posedge aclk);
    axis_running <= 4'h0;
    start_cmd <= 1'b1;
    wait_sig(0, 6);
    chk("own axis start", 2, n);
  endtask : t_stop
  task automatic t_evt;
    wr(ASSS_OFS_IRQ_EN, 32'h0000_1ff0);
    for (int k = 0; k < 9; k++) begin
      wr(ASSS_OFS_SYNC_CFG, 32'(k < 4 ? k + 8 : k - 3) << 16);
      @(posedge aclk);
      events <= asss_evt_t'(9'h001 << k);
      wait_sig(2, 3);
      chk("sync out", 1, n);
      chk("irq low", 0, int_n_q);
      rd(ASSS_OFS_CAUSE);
      chk("cause", 32'h10 << k, d);
      wr(ASSS_OFS_CAUSE, 32'h10 << k);
      repeat (2) @(posedge aclk);
      chk("irq clear", 1, int_n_q);
    end
    wr(ASSS_OFS_IRQ_EN, 32'h0);
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {[1:5], [8:11]})) begin
        wr(ASSS_OFS_SYNC_CFG, 32'(c) << 16);
        @(posedge aclk);
        events <= asss_evt_t'(9'h1ff);
        wait_sig(2, 3);
        chk("sync off", 3, n);
        chk("irq masked", 1, int_n_q);
      end
    end
    rd(8'h1c);
    chk("unmapped", 32'h2, {30'h0, r});
    wr(8'h1c, 32'h0);
    chk("unmapped write", 32'h2, {30'h0, r});
  endtask : t_evt
  task automatic give_verdict;
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    do_reset();
    t_stuck();
    do_reset();
    t_vib();
    t_sync();
    t_stop();
    t_evt();
    give_verdict();
  end
endmodule : asss_axis_tb
`default_nettype wire

// ---- testbench/asss_drv_model.sv ----
// motor driver stand-in that counts extra settle pulses by direction
`default_nettype none
module asss_drv_model
  import asss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire asss_extra_t extra_q,
  output logic [7:0] rev_cnt_q,
  output logic [7:0] fwd_cnt_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // counts clear on every reset, so the bench reads them after its last reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rev_cnt_q <= 8'h00;
      fwd_cnt_q <= 8'h00;
    end else if (extra_q.pulse && extra_q.dir_pos) begin
      fwd_cnt_q <= fwd_cnt_q + 8'h01;
    end else if (extra_q.pulse) begin
      rev_cnt_q <= rev_cnt_q + 8'h01;
    end
  end
endmodule : asss_drv_model
`default_nettype wire
